//--- hsc_pkg.sv
package hsc_pkg;

  // ==========================================================
  // Bus addressing and command words
  // ==========================================================
  localparam logic [6:0]  HSC_DEV_ADDR      = 7'h70;
  localparam logic [15:0] HSC_CMD_SLEEP     = 16'hB098;
  localparam logic [15:0] HSC_CMD_WAKE      = 16'h3517;
  localparam logic [15:0] HSC_CMD_SOFT_RST  = 16'h805D;
  localparam logic [15:0] HSC_CMD_N_ST_T    = 16'h7CA2;
  localparam logic [15:0] HSC_CMD_N_ST_H    = 16'h5C24;
  localparam logic [15:0] HSC_CMD_N_NS_T    = 16'h7866;
  localparam logic [15:0] HSC_CMD_N_NS_H    = 16'h58E0;
  localparam logic [15:0] HSC_CMD_L_ST_T    = 16'h6458;
  localparam logic [15:0] HSC_CMD_L_ST_H    = 16'h44DE;
  localparam logic [15:0] HSC_CMD_L_NS_T    = 16'h609C;
  localparam logic [15:0] HSC_CMD_L_NS_H    = 16'h401A;

  // ==========================================================
  // Check byte
  // ==========================================================
  localparam logic [7:0]  HSC_CRC_POLY      = 8'h31;
  localparam logic [7:0]  HSC_CRC_INIT      = 8'hFF;

  // ==========================================================
  // Timing, in ns, then in core clock cycles (all round down)
  // ==========================================================
  localparam int HSC_CLK_PERIOD_NS          = 100;
  localparam int HSC_POWER_UP_SETTLE_NS     = 240000;
  localparam int HSC_SOFT_RESET_SETTLE_NS   = 240000;
  localparam int HSC_CONV_NORMAL_NS         = 12100000;
  localparam int HSC_CONV_LOW_POWER_NS      = 800000;
  localparam int HSC_PU_CYC  = HSC_POWER_UP_SETTLE_NS / HSC_CLK_PERIOD_NS;
  localparam int HSC_SR_CYC  = HSC_SOFT_RESET_SETTLE_NS / HSC_CLK_PERIOD_NS;
  localparam int HSC_CN_CYC  = HSC_CONV_NORMAL_NS / HSC_CLK_PERIOD_NS;
  localparam int HSC_CL_CYC  = HSC_CONV_LOW_POWER_NS / HSC_CLK_PERIOD_NS;
  localparam int HSC_TMR_W   = 17;
  localparam int HSC_RD_BYTES = 6;

  // ==========================================================
  // Carried groups
  // ==========================================================
  typedef struct packed {
    logic stretch;   // Hold SCL low while converting
    logic hum_first; // Humidity word is sent first
    logic low_power; // Short, low-power conversion
  } hsc_meas_cfg_t;

  typedef struct packed {
    logic [15:0] first;
    logic [15:0] second;
  } hsc_result_t;

  typedef enum logic [1:0] {
    HSC_P_SETTLE, HSC_P_IDLE, HSC_P_SLEEP, HSC_P_MEAS
  } hsc_pwr_t;

  typedef enum logic [3:0] {
    HSC_B_IDLE, HSC_B_ADDR, HSC_B_AACK, HSC_B_WRX, HSC_B_WACK,
    HSC_B_TX, HSC_B_MACK, HSC_B_STRETCH, HSC_B_IGNORE
  } hsc_bus_t;

endpackage

//--- hsc_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module hsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  // ==========================================================
  // Storage and pointers
  // ==========================================================
  logic [WIDTH-1:0] mem_q [DEPTH];  // Flip-flop storage
  logic [AW-1:0]    wr_q;           // Write index
  logic [AW-1:0]    rd_q;           // Read index
  logic [AW:0]      cnt_q;          // Occupancy, honest full/empty
  wire              push = in_valid_i & in_ready_o;
  wire              pop  = out_valid_o & out_ready_i;

  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH)) & ~flush_i;
  assign out_valid_o = (cnt_q != '0) & ~flush_i;
  assign out_data_o  = mem_q[rd_q];

  // Pointers; flush wins so a stale byte never leaks into a new read
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (flush_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (pop)  rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Data words carry no reset
  always_ff @(posedge clk_i) begin
    if (push) mem_q[wr_q] <= in_data_i;
  end
endmodule
`default_nettype wire

//--- hsc_core.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Answer only bus address 0x70
// - Commands are 16-bit words after write header
// - Idle after power-up settle time
// - Idle again after soft reset settle
// - Command 0xB098 enters sleep
// - Command 0x3517 wakes a sleeping device
// - Every measurement converts temperature and humidity
// - Normal-mode commands select stretch and order
// - Low-power commands select stretch and order
// - Conversion ends within 12.1 / 0.8 ms
// - Stretching holds SCL low until done
// - Read sends word, check, word, check
// - Check byte CRC-8 poly 0x31 init 0xFF
// - Soft reset 0x805D accepted when idle
module hsc_core
  import hsc_pkg::*;
#(
  parameter int PU_CYC = HSC_PU_CYC,
  parameter int SR_CYC = HSC_SR_CYC,
  parameter int CN_CYC = HSC_CN_CYC,
  parameter int CL_CYC = HSC_CL_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o,
  input  wire logic [15:0] temp_raw_i,
  input  wire logic [15:0] hum_raw_i,
  output logic             conv_busy_o,
  output logic             conv_low_power_o,
  output logic             sleeping_o,
  output logic             idle_o
);

  // ==========================================================
  // Reset release and pin synchronisers
  // ==========================================================
  logic [1:0] rst_q;               // Reset release chain
  logic [1:0] scl_s_q, sda_s_q;    // Two flops per pin
  logic       scl_d_q, sda_d_q;    // Previous synced level
  wire        rst_n = rst_q[1];

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) rst_q <= 2'h0;
    else          rst_q <= {rst_q[0], 1'b1};
  end

  // Only the second stage and its delayed copy feed logic
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
      scl_d_q <= scl_s_q[1];
      sda_d_q <= sda_s_q[1];
    end
  end

  wire scl  = scl_s_q[1];
  wire sda  = sda_s_q[1];
  wire rise = scl & ~scl_d_q;
  wire fall = ~scl & scl_d_q;
  wire st_ev = scl & scl_d_q & sda_d_q & ~sda;   // START
  wire sp_ev = scl & scl_d_q & ~sda_d_q & sda;   // STOP

  // ==========================================================
  // State declarations
  // ==========================================================
  hsc_pwr_t           pwr_q;        // Power / conversion state
  hsc_bus_t           bus_q;        // Bus protocol state
  logic [HSC_TMR_W-1:0] tmr_q;      // Settle / conversion timer
  hsc_meas_cfg_t      cfg_q;        // Options of last measurement
  hsc_result_t        res_q;        // Captured words in send order
  logic               ready_q;      // Results present to read
  logic [7:0]         sh_q;         // Receive shift register
  logic [7:0]         hi_q;         // First command byte
  logic [7:0]         tx_q;         // Transmit shift register
  logic [3:0]         bcnt_q;       // Bits in current byte
  logic [1:0]         wbyte_q;      // Write bytes taken
  logic [2:0]         sent_q;       // Read bytes loaded
  logic               rd_q;         // Header was a read
  logic               mack_q;       // Master acked last byte
  logic               sda_low_q;    // We pull SDA
  logic               scl_low_q;    // We pull SCL
  logic [2:0]         lidx_q;       // Loader byte index
  logic [7:0]         crc_q;        // Running check value
  logic               lact_q;       // Loader active

  // ==========================================================
  // Command decode
  // ==========================================================
  wire [15:0] cmd     = {hi_q, sh_q};
  wire c_st_t = (cmd == HSC_CMD_N_ST_T) | (cmd == HSC_CMD_L_ST_T);
  wire c_st_h = (cmd == HSC_CMD_N_ST_H) | (cmd == HSC_CMD_L_ST_H);
  wire c_ns_t = (cmd == HSC_CMD_N_NS_T) | (cmd == HSC_CMD_L_NS_T);
  wire c_ns_h = (cmd == HSC_CMD_N_NS_H) | (cmd == HSC_CMD_L_NS_H);
  wire c_low  = (cmd == HSC_CMD_L_ST_T) | (cmd == HSC_CMD_L_ST_H) |
                (cmd == HSC_CMD_L_NS_T) | (cmd == HSC_CMD_L_NS_H);
  wire c_meas = c_st_t | c_st_h | c_ns_t | c_ns_h;
  hsc_meas_cfg_t c_cfg;
  assign c_cfg = '{stretch: c_st_t | c_st_h, hum_first: c_st_h | c_ns_h,
                   low_power: c_low};

  wire asleep  = (pwr_q == HSC_P_SLEEP);
  wire conv    = (pwr_q == HSC_P_MEAS);
  wire settle  = (pwr_q == HSC_P_SETTLE);
  // Header decision after eight address bits
  wire a_match = (sh_q[7:1] == HSC_DEV_ADDR);
  wire a_wr_ok = ~settle & ~conv;
  wire a_rd_ok = ~settle & ~asleep &
                 (conv ? cfg_q.stretch : ready_q);
  wire a_ack   = a_match & (sh_q[0] ? a_rd_ok : a_wr_ok);
  // Second command byte: asleep only the wakeup word is taken
  wire c_ok    = asleep ? (cmd == HSC_CMD_WAKE) : 1'b1;
  wire byte_in = fall & (bcnt_q == 4'h8);
  wire cmd_go  = (bus_q == HSC_B_WRX) & byte_in &
                 (wbyte_q == 2'h1) & c_ok;
  wire rd_go   = (bus_q == HSC_B_ADDR) & byte_in & a_ack & sh_q[0];

  // ==========================================================
  // Result byte stream through the FIFO
  // ==========================================================
  logic [7:0] f_in, f_out;
  logic       f_in_rdy, f_out_vld;
  wire  f_push = lact_q & ready_q & (lidx_q != 3'(HSC_RD_BYTES));
  wire  f_flush = st_ev | sp_ev | rd_go;
  wire  more   = mack_q & (sent_q != 3'(HSC_RD_BYTES));
  wire  tx_ask = (fall & (((bus_q == HSC_B_AACK) & rd_q) |
                  ((bus_q == HSC_B_MACK) & more))) |
                 (bus_q == HSC_B_STRETCH);
  wire  f_pop  = tx_ask & f_out_vld & ~sp_ev & ~st_ev;

  // Bytes 2 and 5 are check bytes; others are word halves
  always_comb begin
    unique case (lidx_q)
      3'h0:    f_in = res_q.first[15:8];
      3'h1:    f_in = res_q.first[7:0];
      3'h3:    f_in = res_q.second[15:8];
      3'h4:    f_in = res_q.second[7:0];
      default: f_in = crc_q;
    endcase
  end

  // Bitwise CRC-8, MSB first, no reflection or final xor
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ HSC_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  wire is_chk = (lidx_q == 3'h2) | (lidx_q == 3'h5);

  // Loader fills the FIFO; stalls whenever the FIFO is full
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lidx_q <= 3'h0;
      crc_q  <= HSC_CRC_INIT;
      lact_q <= 1'b0;
    end else if (rd_go) begin
      lidx_q <= 3'h0;
      crc_q  <= HSC_CRC_INIT;
      lact_q <= 1'b1;
    end else if (st_ev | sp_ev) begin
      lact_q <= 1'b0;
    end else if (f_push & f_in_rdy) begin
      lidx_q <= lidx_q + 3'h1;
      crc_q  <= is_chk ? HSC_CRC_INIT : crc8(crc_q, f_in);
    end
  end

  hsc_fifo #(.WIDTH(8), .DEPTH(4)) u_fifo (
    .clk_i       (core_clk_i),
    .rst_n_i     (rst_n),
    .flush_i     (f_flush),
    .in_valid_i  (f_push),
    .in_ready_o  (f_in_rdy),
    .in_data_i   (f_in),
    .out_valid_o (f_out_vld),
    .out_ready_i (f_pop),
    .out_data_o  (f_out)
  );

  // ==========================================================
  // Power, settle and conversion sequencing
  // ==========================================================
  wire tmr_done = (tmr_q == '0);

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q   <= HSC_P_SETTLE;
      tmr_q   <= HSC_TMR_W'(PU_CYC - 1);
      cfg_q   <= '0;
      res_q   <= '0;
      ready_q <= 1'b0;
    end else begin
      if (!tmr_done) tmr_q <= tmr_q - 1'b1;
      unique case (pwr_q)
        HSC_P_SETTLE: if (tmr_done) pwr_q <= HSC_P_IDLE;
        HSC_P_SLEEP: if (cmd_go) pwr_q <= HSC_P_IDLE;
        HSC_P_MEAS: if (tmr_done) begin
          // Both quantities are captured together
          pwr_q   <= HSC_P_IDLE;
          ready_q <= 1'b1;
          res_q   <= cfg_q.hum_first ? {hum_raw_i, temp_raw_i}
                                     : {temp_raw_i, hum_raw_i};
        end
        HSC_P_IDLE: if (cmd_go) begin
          if (cmd == HSC_CMD_SLEEP) begin
            pwr_q <= HSC_P_SLEEP;
          end else if (cmd == HSC_CMD_SOFT_RST) begin
            pwr_q   <= HSC_P_SETTLE;
            tmr_q   <= HSC_TMR_W'(SR_CYC - 1);
            ready_q <= 1'b0;
            cfg_q   <= '0;
          end else if (c_meas) begin
            pwr_q   <= HSC_P_MEAS;
            cfg_q   <= c_cfg;
            ready_q <= 1'b0;
            tmr_q   <= c_low ? HSC_TMR_W'(CL_CYC - 1)
                             : HSC_TMR_W'(CN_CYC - 1);
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Bus protocol engine
  // ==========================================================
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_q     <= HSC_B_IDLE;
      sh_q      <= 8'h00;
      hi_q      <= 8'h00;
      tx_q      <= 8'h00;
      bcnt_q    <= 4'h0;
      wbyte_q   <= 2'h0;
      sent_q    <= 3'h0;
      rd_q      <= 1'b0;
      mack_q    <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (sp_ev) begin
      bus_q     <= HSC_B_IDLE;   // STOP frees the bus
      sda_low_q <= 1'b0;
    end else if (st_ev) begin
      bus_q     <= HSC_B_ADDR;   // START or repeated START
      bcnt_q    <= 4'h0;
      sda_low_q <= 1'b0;
    end else begin
      // Shift in on every rising edge of a receiving byte
      if (rise && (bus_q == HSC_B_ADDR || bus_q == HSC_B_WRX)) begin
        sh_q   <= {sh_q[6:0], sda};
        bcnt_q <= bcnt_q + 4'h1;
      end
      if (rise && bus_q == HSC_B_MACK) mack_q <= ~sda;
      if (f_pop) begin
        // Next byte goes out on SCL low
        tx_q      <= {f_out[6:0], 1'b0};
        sda_low_q <= ~f_out[7];
        bcnt_q    <= 4'h1;
        sent_q    <= sent_q + 3'h1;
        bus_q     <= HSC_B_TX;
      end else if (fall) begin
        unique case (bus_q)
          HSC_B_ADDR: if (bcnt_q == 4'h8) begin
            rd_q      <= sh_q[0];
            sda_low_q <= a_ack;
            bus_q     <= a_ack ? HSC_B_AACK : HSC_B_IGNORE;
            wbyte_q   <= 2'h0;
            sent_q    <= 3'h0;
          end
          HSC_B_AACK: begin
            sda_low_q <= 1'b0;
            bcnt_q    <= 4'h0;
            // Read with no byte yet: hold the clock
            bus_q     <= rd_q ? HSC_B_STRETCH : HSC_B_WRX;
          end
          HSC_B_WRX: if (bcnt_q == 4'h8) begin
            if (wbyte_q == 2'h0) hi_q <= sh_q;
            sda_low_q <= (wbyte_q == 2'h0) | cmd_go;
            bus_q     <= ((wbyte_q == 2'h0) | cmd_go) ? HSC_B_WACK
                                                      : HSC_B_IGNORE;
            wbyte_q   <= wbyte_q + 2'h1;
          end
          HSC_B_WACK: begin
            sda_low_q <= 1'b0;
            bcnt_q    <= 4'h0;
            bus_q     <= HSC_B_WRX;
          end
          HSC_B_TX: begin
            if (bcnt_q == 4'h8) begin
              sda_low_q <= 1'b0;   // Release for master ack
              bus_q     <= HSC_B_MACK;
            end else begin
              sda_low_q <= ~tx_q[7];
              tx_q      <= {tx_q[6:0], 1'b0};
              bcnt_q    <= bcnt_q + 4'h1;
            end
          end
          HSC_B_MACK: begin
            // Master nack or last byte: stop sending
            bus_q <= more ? HSC_B_STRETCH : HSC_B_IGNORE;
          end
          default: ;
        endcase
      end
    end
  end

  // SCL is pulled one cycle after entering the wait and freed one
  // cycle after the byte is set up, giving data setup before release
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) scl_low_q <= 1'b0;
    else        scl_low_q <= (bus_q == HSC_B_STRETCH) & ~sp_ev;
  end

  // ==========================================================
  // Pins and status
  // ==========================================================
  assign scl_o            = 1'b0;       // Open drain: only low
  assign sda_o            = 1'b0;
  assign scl_oe_n_o       = ~scl_low_q;
  assign sda_oe_n_o       = ~sda_low_q;
  assign conv_busy_o      = conv;
  assign conv_low_power_o = cfg_q.low_power;
  assign sleeping_o       = asleep;
  assign idle_o           = (pwr_q == HSC_P_IDLE);

endmodule
`default_nettype wire

//--- hsc_core_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Port checker for the sensor command port
// ==========================================================
module hsc_core_assertions
  import hsc_pkg::*;
#(
  parameter int PU_CYC = HSC_PU_CYC,
  parameter int SR_CYC = HSC_SR_CYC,
  parameter int CN_CYC = HSC_CN_CYC,
  parameter int CL_CYC = HSC_CL_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic scl_oe_n_o,
  input wire logic conv_busy_o,
  input wire logic conv_low_power_o,
  input wire logic sleeping_o,
  input wire logic idle_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Settle bounds cover both the power-up and the soft reset case
  localparam int SET_MAX = (PU_CYC > SR_CYC ? PU_CYC : SR_CYC) + 4;
  localparam int SET_MIN = (PU_CYC < SR_CYC ? PU_CYC : SR_CYC) - 2;
  int unsigned set_q, bsy_q; // Settle and conversion cycle counts
  // Settle count restarts whenever a settled state shows; conversion count whenever not converting
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      set_q <= 0;
      bsy_q <= 0;
    end else begin
      set_q <= (idle_o | sleeping_o | conv_busy_o) ? 0 : set_q + 1;
      bsy_q <= conv_busy_o ? bsy_q + 1 : 0;
    end
  end
  property p_one_state;
    !(idle_o && sleeping_o) && !(conv_busy_o && (idle_o || sleeping_o));
  endproperty
  a_one_state: assert property (p_one_state)
    else $error("power states overlap");
  property p_sleep_from_idle;
    $rose(sleeping_o) |-> $past(idle_o) && !idle_o;
  endproperty
  a_sleep_from_idle: assert property (p_sleep_from_idle)
    else $error("sleep entered from a non idle state");
  property p_wake_to_idle;
    $fell(sleeping_o) |-> idle_o;
  endproperty
  a_wake_to_idle: assert property (p_wake_to_idle)
    else $error("wake did not land in idle");
  property p_meas_from_idle;
    $rose(conv_busy_o) |-> $past(idle_o);
  endproperty
  a_meas_from_idle: assert property (p_meas_from_idle)
    else $error("conversion started outside idle");
  property p_meas_to_idle;
    $fell(conv_busy_o) |-> idle_o;
  endproperty
  a_meas_to_idle: assert property (p_meas_to_idle)
    else $error("conversion did not return to idle");
  property p_conv_bound;
    conv_busy_o |-> bsy_q < (conv_low_power_o ? CL_CYC : CN_CYC);
  endproperty
  a_conv_bound: assert property (p_conv_bound)
    else $error("conversion ran too long");
  property p_settle_max;
    set_q <= SET_MAX;
  endproperty
  a_settle_max: assert property (p_settle_max)
    else $error("settling ran too long");
  property p_settle_min;
    $rose(idle_o) && !$past(sleeping_o) && !$past(conv_busy_o)
      |-> set_q >= SET_MIN;
  endproperty
  a_settle_min: assert property (p_settle_min)
    else $error("idle reached before settle time");
  property p_quiet_asleep;
    sleeping_o |-> scl_oe_n_o;
  endproperty
  a_quiet_asleep: assert property (p_quiet_asleep)
    else $error("clock held low while asleep");
  property p_stretch_ends;
    !scl_oe_n_o && !conv_busy_o |-> ##[1:40] scl_oe_n_o;
  endproperty
  a_stretch_ends: assert property (p_stretch_ends)
    else $error("clock stretch outlived the conversion");
endmodule
bind hsc_core hsc_core_assertions #(.PU_CYC(PU_CYC), .SR_CYC(SR_CYC),
  .CN_CYC(CN_CYC), .CL_CYC(CL_CYC)) hsc_core_assertions_i (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .scl_oe_n_o(scl_oe_n_o),
  .conv_busy_o(conv_busy_o), .conv_low_power_o(conv_low_power_o),
  .sleeping_o(sleeping_o), .idle_o(idle_o));
`default_nettype wire

//--- hsc_i2c_master.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Bus master model: pulls lines low, otherwise releases them
// ==========================================================
module hsc_i2c_master (
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_oe_n_o,
  output logic      sda_oe_n_o
);
  localparam int QTR = 200; // Quarter of an 800 ns period
  int lag = 0;              // Extra low time for a slow master
  int hold;                 // Bounded wait on a stretched clock
  initial begin
    scl_oe_n_o = 1'b1;
    sda_oe_n_o = 1'b1;
  end
  // One clock: data set in the low phase, sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    #(QTR + lag);
    sda_oe_n_o = b; // A one is released, never driven
    #QTR;
    scl_oe_n_o = 1'b1;
    hold = 0;
    while (scl_i !== 1'b1 && hold < 20000) begin
      #10;
      hold++;
    end
    #QTR;
    s = sda_i;
    #QTR;
    scl_oe_n_o = 1'b0;
  endtask
  // Works from idle and as a repeated start
  task automatic start();
    #QTR;
    sda_oe_n_o = 1'b1;
    #QTR;
    scl_oe_n_o = 1'b1;
    #(2 * QTR);
    sda_oe_n_o = 1'b0;
    #(2 * QTR);
    scl_oe_n_o = 1'b0;
  endtask
  task automatic stop();
    #QTR;
    sda_oe_n_o = 1'b0;
    #QTR;
    scl_oe_n_o = 1'b1;
    #(2 * QTR);
    sda_oe_n_o = 1'b1;
    #(2 * QTR);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(!more, s);
  endtask
endmodule
`default_nettype wire

//--- tb_hsc_core.sv
`timescale 1ns/1ns
`default_nettype none
module tb_hsc_core
  import hsc_pkg::*;
;
  // ==========================================================
  // Clock, reset and wired-AND bus lines
  // ==========================================================
  localparam int PU = 200, SR = 200, CN = 500, CL = 200; // Short counts
  logic clk = 1'b0, rst_b = 1'b0;
  logic [15:0] t_raw = 16'hBEEF, h_raw = 16'h0000;
  logic d_scl, d_scl_n, d_sda, d_sda_n, busy, lowp, slp, idle;
  logic m_scl_n, m_sda_n;
  wire logic scl_w = m_scl_n & (d_scl_n | d_scl); // Pull-up when released
  wire logic sda_w = m_sda_n & (d_sda_n | d_sda);
  int error_cnt = 0, n_compared = 0;
  longint t_rel;
  always #50 clk = ~clk;
  hsc_core #(.PU_CYC(PU), .SR_CYC(SR), .CN_CYC(CN), .CL_CYC(CL)) hsc_core_i (
    .core_clk_i(clk), .rst_b_i(rst_b), .scl_i(scl_w), .scl_o(d_scl),
    .scl_oe_n_o(d_scl_n), .sda_i(sda_w), .sda_o(d_sda), .sda_oe_n_o(d_sda_n),
    .temp_raw_i(t_raw), .hum_raw_i(h_raw), .conv_busy_o(busy),
    .conv_low_power_o(lowp), .sleeping_o(slp), .idle_o(idle));
  hsc_i2c_master hsc_i2c_master_i (.scl_i(scl_w), .sda_i(sda_w),
    .scl_oe_n_o(m_scl_n), .sda_oe_n_o(m_sda_n));
  // ==========================================================
  // Checking, reference check byte and bus transfers
  // ==========================================================
  task automatic chk(input string nm, input logic [47:0] e, g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = HSC_CRC_INIT;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? HSC_CRC_POLY : 8'h00);
    return c;
  endfunction
  task automatic hdr(input logic [7:0] h, output logic a);
    hsc_i2c_master_i.start();
    hsc_i2c_master_i.wbyte(h, a);
    hsc_i2c_master_i.stop();
  endtask
  task automatic cmd(input logic [15:0] c, output logic [2:0] a);
    hsc_i2c_master_i.start();
    hsc_i2c_master_i.wbyte({HSC_DEV_ADDR, 1'b0}, a[2]);
    hsc_i2c_master_i.wbyte(c[15:8], a[1]);
    hsc_i2c_master_i.wbyte(c[7:0], a[0]);
    hsc_i2c_master_i.stop();
  endtask
  // A short read ends on a NACK, then clocks one bit with SDA released
  task automatic rd(input int nb, output logic a, output logic [47:0] d);
    logic [7:0] b;
    logic s;
    d = 48'h0;
    hsc_i2c_master_i.start();
    hsc_i2c_master_i.wbyte({HSC_DEV_ADDR, 1'b1}, a);
    for (int k = 0; k < nb && a; k++) begin
      hsc_i2c_master_i.rbyte(k < nb - 1, b);
      d = {d[39:0], b};
    end
    if (a && nb < 6) begin
      hsc_i2c_master_i.bit_io(1'b1, s);
      chk("sda after nack", 48'h1, {47'h0, s});
    end
    hsc_i2c_master_i.stop();
  endtask
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_power();
    logic a;
    int n;
    hdr({HSC_DEV_ADDR, 1'b0}, a);
    chk("hdr settling", 0, a);
    n = 0;
    while (idle !== 1'b1 && n < PU + 20) begin
      @(negedge clk);
      n++;
    end
    chk("settle cycles", 1, ($time - t_rel) / 100 inside {[PU:PU + 8]});
    for (int i = 0; i < 7; i++) begin
      hdr({HSC_DEV_ADDR ^ (7'h1 << i), 1'b0}, a);
      chk("foreign addr", 0, a);
    end
    hdr({HSC_DEV_ADDR, 1'b0}, a);
    chk("own addr", 1, a);
    $display("t_power done");
  endtask
  task automatic t_sleep();
    logic [2:0] a;
    logic h;
    cmd(HSC_CMD_SLEEP, a);
    chk("sleep", 5'b11110, {a, slp, idle});
    cmd(HSC_CMD_N_NS_T, a);
    chk("meas asleep", 4'b1100, {a, busy});
    cmd(HSC_CMD_SLEEP, a);
    chk("sleep asleep", 3'b110, a);
    hdr({HSC_DEV_ADDR, 1'b1}, h);
    chk("read asleep", 0, h);
    cmd(HSC_CMD_WAKE, a);
    chk("wake", 5'b11101, {a, slp, idle});
    $display("t_sleep done");
  endtask
  // Code index: bit0 humidity first, bit1 no stretch, bit2 low power
  task automatic t_meas();
    logic [15:0] codes [8];
    logic [47:0] d;
    logic [15:0] w1, w2;
    logic [2:0] a;
    logic h;
    int n;
    codes = '{HSC_CMD_N_ST_T, HSC_CMD_N_ST_H, HSC_CMD_N_NS_T, HSC_CMD_N_NS_H,
              HSC_CMD_L_ST_T, HSC_CMD_L_ST_H, HSC_CMD_L_NS_T, HSC_CMD_L_NS_H};
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      #5;
      t_raw = 16'hBEEF ^ 16'(i);
      h_raw = 16'h5A00 | 16'(i);
      w1 = i[0] ? h_raw : t_raw;
      w2 = i[0] ? t_raw : h_raw;
      hsc_i2c_master_i.lag = i[1] ? 0 : 300; // Slow master on stretch
      cmd(codes[i], a);
      chk("meas acks", 3'b111, a);
      chk("conv mode", {1'b1, i[2]}, {busy, lowp});
      if (i[1]) begin
        rd(6, h, d);
        chk("hdr converting", 0, h);
        n = 0;
        while (busy === 1'b1 && n < CN) begin
          @(negedge clk);
          n++;
        end
        chk("conv ends", 1, busy === 1'b0 && n < (i[2] ? CL : CN));
      end
      rd(i == 7 ? 2 : 6, h, d);
      chk("read hdr", 1, h);
      if (i == 7) rd(6, h, d);
      chk("result", {w1, crc8(w1), w2, crc8(w2)}, d);
      chk("idle after", 1, idle);
    end
    $display("t_meas done");
  endtask
  task automatic t_reset();
    logic [47:0] d;
    logic [2:0] a;
    logic h;
    int n;
    cmd(HSC_CMD_SOFT_RST, a);
    chk("soft reset", 4'b1110, {a, idle});
    hdr({HSC_DEV_ADDR, 1'b0}, h);
    chk("hdr settling", 0, h);
    n = 0;
    while (idle !== 1'b1 && n < SR) begin
      @(negedge clk);
      n++;
    end
    chk("idle again", 1, idle);
    rd(6, h, d);
    chk("results gone", 0, h);
    $display("t_reset done");
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence: power-up, sleep and wake, measure and read, soft reset kept in that order
  initial begin
    repeat (6) @(posedge clk);
    #5;
    rst_b = 1'b1;
    t_rel = $time;
    t_power();
    t_sleep();
    t_meas();
    t_reset();
    summarize();
  end
  // Whole run needs about 12000 cycles; allow five times that
  initial begin
    #6000000;
    error_cnt++;
    $display("MISMATCH watchdog expected finish seen hang");
    summarize();
  end
endmodule
`default_nettype wire
